// ### fss_far_side.sv
// far-side model: panel, terminals and upper controller as sources
`timescale 1ns/1ps
module fss_far_side (
  // frequency sources, 0.01 Hz unless noted
  output logic [fss_pkg::FREQ_W-1:0]  serial_freq,
  output logic [fss_pkg::FREQ_W-1:0]  analog_input_one,
  output logic [fss_pkg::FREQ_W-1:0]  analog_input_two,
  output logic [fss_pkg::PULSE_W-1:0] digital_input_six_hz,
  output logic [fss_pkg::FREQ_W-1:0]  seq_freq,
  output logic [fss_pkg::FREQ_W-1:0]  multi_freq,
  output logic [fss_pkg::FREQ_W-1:0]  pid_freq,
  output logic [9:0]                  kpot_pos,
  output logic [fss_pkg::FREQ_W-1:0]  solar_power_tracking,
  output logic [fss_pkg::FREQ_W-1:0]  pot_freq,
  // run requests from each channel
  output logic [1:0]                  panel_run_cmd,
  output logic [1:0]                  serial_run_cmd,
  output logic                        forward_run_input,
  output logic                        reverse_run_input,
  output logic                        jog_fwd_input,
  output logic                        jog_rev_input
);
  import fss_pkg::*;
  // distinct levels so that a wrong source pick shows at once
  assign serial_freq          = 16'h03e8;
  assign analog_input_one     = 16'h07d0;
  assign analog_input_two     = 16'h0bb8;
  assign digital_input_six_hz = 17'h061a8;
  assign seq_freq             = 16'h044c;
  assign multi_freq           = 16'h04b0;
  assign pid_freq             = 16'h0514;
  assign kpot_pos             = 10'h3ff;
  assign solar_power_tracking = 16'h0578;
  assign pot_freq             = 16'h05dc;
  // each channel asks for a different direction, jog covers the terminal path
  assign panel_run_cmd        = 2'h1;
  assign serial_run_cmd       = 2'h3;
  assign forward_run_input    = 1'b0;
  assign reverse_run_input    = 1'b0;
  assign jog_fwd_input        = 1'b0;
  assign jog_rev_input        = 1'b1;
endmodule // fss_far_side

// ### fss_pkg.sv
// constants and types for the frequency setpoint selector
package fss_pkg;
  // frequency units: 0.01 Hz, 16 bits
  localparam int FREQ_W = 16;
  localparam int SEL_W = 4;
  // run command channel codes
  localparam logic [1:0] CMD_PANEL = 2'h0;
  localparam logic [1:0] CMD_TERM = 2'h1;
  localparam logic [1:0] CMD_SERIAL = 2'h2;
  // source codes shared by A and B
  localparam logic [3:0] SRC_PANEL = 4'h0;
  localparam logic [3:0] SRC_UPDOWN = 4'h1;
  localparam logic [3:0] SRC_SERIAL = 4'h2;
  localparam logic [3:0] SRC_AIN1 = 4'h3;
  localparam logic [3:0] SRC_AIN2 = 4'h4;
  localparam logic [3:0] SRC_PULSE = 4'h5;
  localparam logic [3:0] SRC_SEQ = 4'h6;
  localparam logic [3:0] SRC_MULTI = 4'h7;
  localparam logic [3:0] SRC_PID = 4'h8;
  localparam logic [3:0] SRC_KPOT = 4'h9;
  localparam logic [3:0] SRC_SOLAR = 4'ha;
  localparam logic [3:0] SRC_POT = 4'hb;
  localparam logic [3:0] SRC_A_DEF = 4'h9;
  localparam logic [3:0] SRC_B_DEF = 4'h3;
  localparam logic [3:0] SRC_MAX = 4'hb;
  // combination codes
  localparam logic [3:0] CMB_A = 4'h0;
  localparam logic [3:0] CMB_ADD = 4'h1;
  localparam logic [3:0] CMB_SUB = 4'h2;
  localparam logic [3:0] CMB_ABS = 4'h3;
  localparam logic [3:0] CMB_MAX = 4'h4;
  localparam logic [3:0] CMB_MIN = 4'h5;
  localparam logic [3:0] CMB_SW_KB = 4'h6;
  localparam logic [3:0] CMB_SW_ADD = 4'h7;
  localparam logic [3:0] CMB_SW_SUB = 4'h8;
  localparam logic [3:0] CMB_LIM = 4'h9;
  // control mode codes
  localparam logic [2:0] CTL_VF = 3'h0;
  localparam logic [2:0] CTL_ADV_VF = 3'h1;
  localparam logic [2:0] CTL_MAX = 3'h4;
  localparam logic [2:0] CTL_RSVD = 3'h3;
  localparam logic [4:0] MACRO_MAX = 5'h14;
  localparam logic [4:0] MACRO_APP_MAX = 5'h07;
  localparam logic [1:0] LANG_MAX = 2'h2;
  // weight K in 0.01 units
  localparam logic [9:0] K_MIN = 10'h001;
  localparam logic [9:0] K_MAX = 10'h3e8;
  localparam logic [9:0] K_DEF = 10'h064;
  localparam int K_SCALE = 100;
  // pulse input full scale 50 kHz
  localparam int PULSE_FULL_HZ = 50000;
  localparam int PULSE_W = 17;
  // up/down ramp: one step per tick of the rate prescaler
  localparam int UD_RATE_W = 16;
  // up/down adjustment range
  localparam int ADJ_W = 18;
endpackage : fss_pkg

// ### fss_selector.sv
// frequency setpoint selection, combination and limiting
`timescale 1ns/1ps
module fss_selector #(
  parameter bit RATED_BELOW_55KW = 1'b1
) (
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        resetn,
  // parameter writes, each in-range code is taken when its strobe is high
  input  wire logic                        cmd_chan_we,
  input  wire logic [1:0]                  cmd_chan_wdata,
  input  wire logic                        src_a_we,
  input  wire logic [fss_pkg::SEL_W-1:0]   src_a_wdata,
  input  wire logic                        src_b_we,
  input  wire logic [fss_pkg::SEL_W-1:0]   src_b_wdata,
  input  wire logic                        combine_we,
  input  wire logic [fss_pkg::SEL_W-1:0]   combine_wdata,
  input  wire logic                        ctl_mode_we,
  input  wire logic [2:0]                  ctl_mode_wdata,
  input  wire logic                        macro_we,
  input  wire logic [4:0]                  macro_wdata,
  input  wire logic                        lang_we,
  input  wire logic [1:0]                  lang_wdata,
  input  wire logic                        weight_we,
  input  wire logic [9:0]                  weight_wdata,
  // frequency parameters, 0.01 Hz
  input  wire logic [fss_pkg::FREQ_W-1:0]  panel_base,
  input  wire logic [fss_pkg::FREQ_W-1:0]  term_base,
  input  wire logic [fss_pkg::FREQ_W-1:0]  max_freq,
  input  wire logic [fss_pkg::FREQ_W-1:0]  upper_limit,
  input  wire logic [fss_pkg::FREQ_W-1:0]  lower_limit,
  input  wire logic                        panel_store_off,
  // panel keys and up/down terminals
  input  wire logic                        panel_up_pulse,
  input  wire logic                        panel_down_pulse,
  input  wire logic                        panel_adj_clear,
  input  wire logic                        term_up,
  input  wire logic                        term_down,
  input  wire logic                        term_adj_clear,
  input  wire logic [fss_pkg::UD_RATE_W-1:0] ud_rate_div,
  input  wire logic                        power_loss,
  // run command sources
  input  wire logic [1:0]                  panel_run_cmd,
  input  wire logic                        forward_run_input,
  input  wire logic                        reverse_run_input,
  input  wire logic                        jog_fwd_input,
  input  wire logic                        jog_rev_input,
  input  wire logic [1:0]                  serial_run_cmd,
  // other frequency sources, 0.01 Hz except the pulse input in Hz and the kpot position
  input  wire logic [fss_pkg::FREQ_W-1:0]  serial_freq,
  input  wire logic [fss_pkg::FREQ_W-1:0]  analog_input_one,
  input  wire logic [fss_pkg::FREQ_W-1:0]  analog_input_two,
  input  wire logic [fss_pkg::PULSE_W-1:0] digital_input_six_hz,
  input  wire logic [fss_pkg::FREQ_W-1:0]  seq_freq,
  input  wire logic [fss_pkg::FREQ_W-1:0]  multi_freq,
  input  wire logic [fss_pkg::FREQ_W-1:0]  pid_freq,
  input  wire logic [9:0]                  kpot_pos,
  input  wire logic [fss_pkg::FREQ_W-1:0]  solar_power_tracking,
  input  wire logic [fss_pkg::FREQ_W-1:0]  pot_freq,
  // switch inputs for functions 29, 30, 31
  input  wire logic                        sw_to_kb,
  input  wire logic                        sw_to_add,
  input  wire logic                        sw_to_sub,
  // outputs
  output logic [1:0]                       run_cmd,
  output logic [1:0]                       cmd_chan,
  output logic [fss_pkg::SEL_W-1:0]        src_a_sel,
  output logic [fss_pkg::SEL_W-1:0]        src_b_sel,
  output logic [fss_pkg::SEL_W-1:0]        combine_sel,
  output logic [2:0]                       ctl_mode,
  output logic [4:0]                       macro_sel,
  output logic                             macro_is_preset,
  output logic [1:0]                       lang_sel,
  output logic [9:0]                       weight_k,
  output logic signed [fss_pkg::ADJ_W-1:0] panel_adj_saved,
  output logic [fss_pkg::FREQ_W-1:0]       setpoint
);
  import fss_pkg::*;

  logic signed [ADJ_W-1:0] panel_adj_reg;
  logic signed [ADJ_W-1:0] term_adj_reg;
  logic [UD_RATE_W-1:0]    ud_cnt_reg;
  logic                    ud_tick;
  logic [FREQ_W-1:0]       freq_a;
  logic [FREQ_W-1:0]       freq_b;
  // K*B reaches ten times a full-scale B, so the signed path is five bits wider than a frequency
  logic signed [ADJ_W+2:0] kb;
  logic signed [ADJ_W+2:0] a_s;
  logic signed [ADJ_W+2:0] comb;
  logic [FREQ_W-1:0]       panel_sp;
  logic [FREQ_W-1:0]       term_sp;

  // parameter selectors; out-of-range writes are ignored
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cmd_chan    <= CMD_PANEL;
      src_a_sel   <= SRC_A_DEF;
      src_b_sel   <= SRC_B_DEF;
      combine_sel <= CMB_A;
      ctl_mode    <= RATED_BELOW_55KW ? CTL_ADV_VF : CTL_VF;
      macro_sel   <= 5'h00;
      lang_sel    <= 2'h0;
      weight_k    <= K_DEF;
    end else begin
      // accepted even while running, no stop needed
      if (cmd_chan_we && cmd_chan_wdata <= CMD_SERIAL) cmd_chan <= cmd_chan_wdata;
      if (src_a_we && src_a_wdata <= SRC_MAX) src_a_sel <= src_a_wdata;
      if (src_b_we && src_b_wdata <= SRC_MAX) src_b_sel <= src_b_wdata;
      if (combine_we && combine_wdata <= CMB_LIM) combine_sel <= combine_wdata;
      if (ctl_mode_we && ctl_mode_wdata <= CTL_MAX) ctl_mode <= ctl_mode_wdata;
      if (macro_we && macro_wdata <= MACRO_MAX) macro_sel <= macro_wdata;
      if (lang_we && lang_wdata <= LANG_MAX) lang_sel <= lang_wdata;
      if (weight_we && weight_wdata >= K_MIN && weight_wdata <= K_MAX) begin
        weight_k <= weight_wdata;
      end
    end
  end

  // macros above 7 are reserved and select no preset
  assign macro_is_preset = (macro_sel <= MACRO_APP_MAX);

  // run command follows the live channel combinationally
  always_comb begin
    unique case (cmd_chan)
      CMD_PANEL: run_cmd = panel_run_cmd;
      CMD_TERM: run_cmd = {reverse_run_input | jog_rev_input,
                           forward_run_input | jog_fwd_input};
      CMD_SERIAL: run_cmd = serial_run_cmd;
      default: run_cmd = 2'h0;
    endcase
  end

  // up/down rate prescaler; a divider of zero steps every cycle
  always_ff @(posedge sys_clk) begin
    if (!resetn || ud_tick) ud_cnt_reg <= '0;
    else ud_cnt_reg <= ud_cnt_reg + 1'b1;
  end
  assign ud_tick = (ud_cnt_reg >= ud_rate_div);

  // terminal adjustment: clear has priority over stepping
  always_ff @(posedge sys_clk) begin
    if (!resetn) term_adj_reg <= '0;
    else if (term_adj_clear) term_adj_reg <= '0;
    else if (ud_tick && term_up && !term_down) begin
      if (term_sp < max_freq) term_adj_reg <= term_adj_reg + 1'b1;
    end else if (ud_tick && term_down && !term_up) begin
      if (term_sp > lower_limit) term_adj_reg <= term_adj_reg - 1'b1;
    end
  end

  // panel adjustment from keys or encoder
  always_ff @(posedge sys_clk) begin
    if (!resetn) panel_adj_reg <= '0;
    else if (panel_adj_clear) panel_adj_reg <= '0;
    else if (panel_up_pulse && !panel_down_pulse && panel_sp < max_freq) begin
      panel_adj_reg <= panel_adj_reg + 1'b1;
    end else if (panel_down_pulse && !panel_up_pulse && panel_sp > lower_limit) begin
      panel_adj_reg <= panel_adj_reg - 1'b1;
    end
  end

  // value handed to nonvolatile store on power loss, zero when storing is off
  always_ff @(posedge sys_clk) begin
    if (!resetn) panel_adj_saved <= '0;
    else if (power_loss) panel_adj_saved <= panel_store_off ? '0 : panel_adj_reg;
  end

  // base plus adjustment, bounded between lower limit and max frequency
  function automatic logic [FREQ_W-1:0] bound_sum(input logic [FREQ_W-1:0] base,
                                                  input logic signed [ADJ_W-1:0] adj,
                                                  input logic [FREQ_W-1:0] lo,
                                                  input logic [FREQ_W-1:0] hi);
    logic signed [ADJ_W+1:0] s;
    s = $signed({2'b00, base}) + adj;
    if (s > $signed({2'b00, hi})) return hi;
    if (s < $signed({2'b00, lo})) return lo;
    return s[FREQ_W-1:0];
  endfunction

  assign panel_sp = bound_sum(panel_base, panel_adj_reg, lower_limit, max_freq);
  assign term_sp = bound_sum(term_base, term_adj_reg, lower_limit, max_freq);

  // one source mux, used for both A and B
  function automatic logic [FREQ_W-1:0] pick(input logic [SEL_W-1:0] sel);
    logic [FREQ_W+PULSE_W-1:0] p;
    logic [FREQ_W+9:0] k;
    p = '0;
    k = '0;
    unique case (sel)
      SRC_PANEL: return panel_sp;
      SRC_UPDOWN: return term_sp;
      SRC_SERIAL: return serial_freq;
      SRC_AIN1: return analog_input_one;
      SRC_AIN2: return analog_input_two;
      SRC_PULSE: begin
        p = FREQ_W'(max_freq) * digital_input_six_hz;
        return (digital_input_six_hz >= PULSE_W'(PULSE_FULL_HZ)) ? max_freq
               : FREQ_W'(p / PULSE_FULL_HZ);
      end
      SRC_SEQ: return seq_freq;
      SRC_MULTI: return multi_freq;
      SRC_PID: return pid_freq;
      SRC_KPOT: begin
        k = max_freq * kpot_pos;
        return FREQ_W'(k / 1023);
      end
      SRC_SOLAR: return solar_power_tracking;
      SRC_POT: return pot_freq;
      default: return '0;
    endcase
  endfunction

  // process form, so that a change in any source, not only the code, re-evaluates
  always_comb freq_a = pick(src_a_sel);
  always_comb freq_b = pick(src_b_sel);

  // weighted auxiliary and combination, signed
  always_comb begin
    logic [FREQ_W+9:0] prod;
    prod = freq_b * weight_k;
    kb = $signed({1'b0, (ADJ_W+2)'(prod / K_SCALE)});
    a_s = $signed({5'b00000, freq_a});
    unique case (combine_sel)
      CMB_ADD: comb = a_s + kb;
      CMB_SUB: comb = a_s - kb;
      CMB_ABS: comb = (a_s >= kb) ? a_s - kb : kb - a_s;
      CMB_MAX: comb = (a_s >= kb) ? a_s : kb;
      CMB_MIN: comb = (a_s <= kb) ? a_s : kb;
      CMB_SW_KB: comb = sw_to_kb ? kb : a_s;
      CMB_SW_ADD: comb = sw_to_add ? a_s + kb : a_s;
      CMB_SW_SUB: comb = sw_to_sub ? a_s - kb : a_s;
      default: comb = a_s;
    endcase
  end

  // final clamp; negative results run at the lower limit
  always_ff @(posedge sys_clk) begin
    if (!resetn) setpoint <= '0;
    else if (comb > $signed({5'b00000, upper_limit})) setpoint <= upper_limit;
    else if (comb < $signed({5'b00000, lower_limit})) setpoint <= lower_limit;
    else setpoint <= comb[FREQ_W-1:0];
  end

  // assertions
  property p_chan_live;
    @(posedge sys_clk) disable iff (!resetn)
      cmd_chan_we && cmd_chan_wdata == CMD_SERIAL |=> run_cmd == serial_run_cmd;
  endproperty
  a_chan_live: assert property (p_chan_live) else $error("channel change not applied");

  property p_clamp;
    @(posedge sys_clk) disable iff (!resetn)
      ##1 (setpoint <= $past(upper_limit) || $past(upper_limit) < $past(lower_limit));
  endproperty
  a_clamp: assert property (p_clamp) else $error("setpoint above upper limit");

  property p_hold;
    @(posedge sys_clk) disable iff (!resetn)
      term_up && term_down && !term_adj_clear |=> $stable(term_adj_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("up/down both closed changed adjustment");

  property p_clear;
    @(posedge sys_clk) disable iff (!resetn)
      term_adj_clear |=> term_adj_reg == 0;
  endproperty
  a_clear: assert property (p_clear) else $error("terminal adjustment not cleared");

  property p_weight;
    @(posedge sys_clk) disable iff (!resetn)
      weight_we && (weight_wdata > K_MAX || weight_wdata < K_MIN) |=> $stable(weight_k);
  endproperty
  a_weight: assert property (p_weight) else $error("weight out of range accepted");

  property p_src_range;
    @(posedge sys_clk) disable iff (!resetn)
      src_a_sel <= SRC_MAX && src_b_sel <= SRC_MAX;
  endproperty
  a_src_range: assert property (p_src_range) else $error("source code out of range");

  property p_mode_range;
    @(posedge sys_clk) disable iff (!resetn)
      ctl_mode_we && ctl_mode_wdata > CTL_MAX |=> $stable(ctl_mode);
  endproperty
  a_mode_range: assert property (p_mode_range) else $error("bad control mode accepted");

  property p_sw_a;
    @(posedge sys_clk) disable iff (!resetn)
      combine_sel == CMB_SW_KB && !sw_to_kb && freq_a <= upper_limit
      && freq_a >= lower_limit && $stable(freq_a) |=> setpoint == $past(freq_a);
  endproperty
  a_sw_a: assert property (p_sw_a) else $error("switch inactive did not return to A");

endmodule // fss_selector

// ### tb_frequency_setpoint_selector.sv
// self-checking bench for the frequency setpoint selector
`timescale 1ns/1ps
module tb_frequency_setpoint_selector;
  import fss_pkg::*;
  // single-bit controls and flags
  logic sys_clk, resetn, cmd_chan_we, src_a_we, src_b_we, combine_we, ctl_mode_we;
  logic macro_we, lang_we, weight_we, panel_store_off, panel_up_pulse, panel_down_pulse;
  logic panel_adj_clear, term_up, term_down, term_adj_clear, power_loss, macro_is_preset;
  logic forward_run_input, reverse_run_input, jog_fwd_input, jog_rev_input;
  logic sw_to_kb, sw_to_add, sw_to_sub;
  // codes and registers
  logic [1:0]         cmd_chan_wdata, lang_wdata, panel_run_cmd, serial_run_cmd;
  logic [1:0]         run_cmd, cmd_chan, lang_sel;
  logic [SEL_W-1:0]   src_a_wdata, src_b_wdata, combine_wdata, src_a_sel, src_b_sel, combine_sel;
  logic [2:0]         ctl_mode_wdata, ctl_mode;
  logic [4:0]         macro_wdata, macro_sel;
  logic [9:0]         weight_wdata, kpot_pos, weight_k;
  // frequencies
  logic [FREQ_W-1:0]  panel_base, term_base, max_freq, upper_limit, lower_limit, setpoint;
  logic [FREQ_W-1:0]  serial_freq, analog_input_one, analog_input_two, seq_freq, multi_freq;
  logic [FREQ_W-1:0]  pid_freq, solar_power_tracking, pot_freq, s1;
  logic [UD_RATE_W-1:0] ud_rate_div;
  logic [PULSE_W-1:0] digital_input_six_hz;
  logic signed [ADJ_W-1:0] panel_adj_saved;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  // expected setpoints: upper limit 45.00 Hz, lower 5.00 Hz, max 50.00 Hz
  logic [15:0] src_exp [12] = '{16'h0640, 16'h06a4, 16'h03e8, 16'h07d0, 16'h0bb8, 16'h09c4,
                                16'h044c, 16'h04b0, 16'h0514, 16'h1194, 16'h0578, 16'h05dc};
  logic [15:0] cmb_exp [10] = '{16'h0bb8, 16'h1194, 16'h01f4, 16'h03e8, 16'h0fa0, 16'h0bb8,
                                16'h0bb8, 16'h0bb8, 16'h0bb8, 16'h0bb8};
  logic [15:0] sw_exp [3] = '{16'h0fa0, 16'h1194, 16'h01f4};
  logic [1:0]  run_exp [3] = '{2'h1, 2'h2, 2'h3};

  fss_selector i_fss_selector (.*);
  fss_far_side i_fss_far_side (.*);

  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // wait edges, then step past them so registered outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe; the value is truncated to the field width on purpose
  task automatic wr(input int f, input logic [9:0] v);
    @(posedge sys_clk);
    case (f)
      0: begin cmd_chan_we <= 1'b1; cmd_chan_wdata <= v[1:0]; end
      1: begin src_a_we <= 1'b1; src_a_wdata <= v[3:0]; end
      2: begin src_b_we <= 1'b1; src_b_wdata <= v[3:0]; end
      3: begin combine_we <= 1'b1; combine_wdata <= v[3:0]; end
      4: begin ctl_mode_we <= 1'b1; ctl_mode_wdata <= v[2:0]; end
      5: begin macro_we <= 1'b1; macro_wdata <= v[4:0]; end
      6: begin lang_we <= 1'b1; lang_wdata <= v[1:0]; end
      default: begin weight_we <= 1'b1; weight_wdata <= v; end
    endcase
    @(posedge sys_clk);
    {cmd_chan_we, src_a_we, src_b_we, combine_we, ctl_mode_we, macro_we, lang_we, weight_we} <= 8'h00;
  endtask

  function automatic logic [9:0] rd(input int f);
    case (f)
      0: return {8'h00, cmd_chan};
      1: return {6'h00, src_a_sel};
      2: return {6'h00, src_b_sel};
      3: return {6'h00, combine_sel};
      4: return {7'h00, ctl_mode};
      5: return {5'h00, macro_sel};
      6: return {8'h00, lang_sel};
      default: return weight_k;
    endcase
  endfunction

  // write then read back a selector
  task automatic wc(input int f, input logic [9:0] v, input logic [9:0] e);
    wr(f, v);
    wt(2);
    chk(rd(f), e);
  endtask

  // main sequence
  initial begin
    resetn = 1'b0;
    {cmd_chan_we, src_a_we, src_b_we, combine_we, ctl_mode_we, macro_we, lang_we, weight_we} = 8'h00;
    {cmd_chan_wdata, lang_wdata, src_a_wdata, src_b_wdata, combine_wdata} = 16'h0000;
    {ctl_mode_wdata, macro_wdata, weight_wdata} = 18'h00000;
    panel_base = 16'h0640;
    term_base = 16'h06a4;
    max_freq = 16'h1388;
    upper_limit = 16'h1194;
    lower_limit = 16'h01f4;
    {panel_store_off, panel_up_pulse, panel_down_pulse, panel_adj_clear, power_loss} = 5'h00;
    {term_up, term_down, term_adj_clear, sw_to_kb, sw_to_add, sw_to_sub} = 6'h00;
    ud_rate_div = 16'h0000;
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    wt(1);
    chk(rd(0), 10'h000);
    chk(rd(1), 10'h009);
    chk(rd(2), 10'h003);
    chk(rd(3), 10'h000);
    chk(rd(4), 10'h001);
    chk(rd(5), 10'h000);
    chk(rd(6), 10'h000);
    chk(rd(7), 10'h064);
    $display("test reset done");
    // every source code in turn as A, kpot full scale hits the upper limit
    for (int i = 0; i < 12; i++) begin
      wr(1, 10'(i));
      wt(3);
      chk(setpoint, src_exp[i]);
    end
    $display("test sources done");
    // A = 30.00 Hz, B = 10.00 Hz, K = 4.00
    wr(1, 10'h004);
    wr(2, 10'h002);
    wr(7, 10'h190);
    for (int c = 0; c < 10; c++) begin
      wr(3, 10'(c));
      wt(3);
      chk(setpoint, cmb_exp[c]);
    end
    for (int c = 6; c < 9; c++) begin
      wr(3, 10'(c));
      @(posedge sys_clk);
      {sw_to_sub, sw_to_add, sw_to_kb} <= 3'(1 << (c - 6));
      wt(3);
      chk(setpoint, sw_exp[c - 6]);
      @(posedge sys_clk);
      {sw_to_sub, sw_to_add, sw_to_kb} <= 3'h0;
      wt(3);
      chk(setpoint, 16'h0bb8);
    end
    $display("test combine done");
    // out-of-range codes leave the old value in place
    wc(1, 10'h00c, 10'h004);
    wc(2, 10'h00c, 10'h002);
    wc(3, 10'h00a, 10'h008);
    wc(7, 10'h000, 10'h190);
    wc(7, 10'h3e9, 10'h190);
    wc(7, 10'h3e8, 10'h3e8);
    wc(7, 10'h001, 10'h001);
    for (int i = 0; i < 5; i++) wc(4, 10'(i), 10'(i));
    wc(4, 10'h005, 10'h004);
    wc(5, 10'h007, 10'h007);
    chk(macro_is_preset, 1'b1);
    wc(5, 10'h008, 10'h008);
    chk(macro_is_preset, 1'b0);
    wc(5, 10'h014, 10'h014);
    wc(5, 10'h015, 10'h014);
    for (int i = 0; i < 3; i++) wc(6, 10'(i), 10'(i));
    wc(6, 10'h003, 10'h002);
    wc(0, 10'h003, 10'h000);
    $display("test limits done");
    // channel switched on the fly, each channel asks differently
    for (int ch = 0; ch < 3; ch++) begin
      wr(0, 10'(ch));
      wt(1);
      chk(run_cmd, run_exp[ch]);
    end
    $display("test channel done");
    // panel keys: five up, two down, then save and clear
    wr(3, 10'h000);
    wr(1, 10'h000);
    for (int i = 0; i < 7; i++) begin
      @(posedge sys_clk);
      if (i < 5) panel_up_pulse <= 1'b1;
      else panel_down_pulse <= 1'b1;
      @(posedge sys_clk);
      {panel_up_pulse, panel_down_pulse} <= 2'h0;
    end
    wt(3);
    chk(setpoint, 16'h0643);
    @(posedge sys_clk);
    power_loss <= 1'b1;
    @(posedge sys_clk);
    power_loss <= 1'b0;
    wt(2);
    chk(panel_adj_saved, 32'h3);
    @(posedge sys_clk);
    panel_store_off <= 1'b1;
    power_loss <= 1'b1;
    @(posedge sys_clk);
    power_loss <= 1'b0;
    wt(2);
    chk(panel_adj_saved, 32'h0);
    @(posedge sys_clk);
    panel_adj_clear <= 1'b1;
    @(posedge sys_clk);
    panel_adj_clear <= 1'b0;
    wt(3);
    chk(setpoint, 16'h0640);
    $display("test panel done");
    // terminals: up, both held, down, clear, then down into the lower limit
    wr(1, 10'h001);
    @(posedge sys_clk);
    term_up <= 1'b1;
    repeat (10) @(posedge sys_clk);
    term_down <= 1'b1;
    wt(4);
    s1 = setpoint;
    chk(s1, 16'h06ae);
    wt(10);
    chk(setpoint, s1);
    @(posedge sys_clk);
    term_up <= 1'b0;
    repeat (5) @(posedge sys_clk);
    term_down <= 1'b0;
    wt(4);
    chk(setpoint, 16'h06a9);
    @(posedge sys_clk);
    term_adj_clear <= 1'b1;
    @(posedge sys_clk);
    term_adj_clear <= 1'b0;
    wt(3);
    chk(setpoint, 16'h06a4);
    @(posedge sys_clk);
    term_base <= 16'h0258;
    term_down <= 1'b1;
    repeat (300) @(posedge sys_clk);
    term_down <= 1'b0;
    wt(3);
    chk(setpoint, 16'h01f4);
    $display("test terminal done");
    summarize();
  end
endmodule // tb_frequency_setpoint_selector
